// ### core/tmr_defines.vh
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// Register byte offsets on the APB
`define TMR_ADDR_W 12
`define TMR_OFF_CONTROL 12'h000
`define TMR_OFF_COUNT 12'h004
`define TMR_OFF_STATUS 12'h008

// Control register layout
`define TMR_CTL_W 16
`define TMR_CTL_RESET 16'h0000
`define TMR_CTL_WMASK 16'ha076
`define TMR_BIT_RUN 15
`define TMR_BIT_SIDL 13
`define TMR_BIT_GATE 6
`define TMR_BIT_PS_HI 5
`define TMR_BIT_PS_LO 4
`define TMR_BIT_SYNC 2
`define TMR_BIT_TCS 1

// Count register
`define TMR_CNT_W 16
`define TMR_CNT_RESET 16'h0000

// Status register layout
`define TMR_ST_RUNNING 0
`define TMR_ST_IDLE_HALT 1
`define TMR_ST_PIN_LEVEL 2
`define TMR_ST_WR_LOCK 3

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define TMR_PS_W 8
`define TMR_PS_TERM_1 8'h00
`define TMR_PS_TERM_8 8'h07
`define TMR_PS_TERM_64 8'h3f
`define TMR_PS_TERM_256 8'hff

`endif

// ### core/tmr_prescaler.v
`timescale 1ns/1ns
`include "tmr_defines.vh"

module tmr_prescaler #(
	parameter PS_W = `TMR_PS_W
) (
	input wire pclk,
	input wire presetn,
	input wire clear,
	input wire tick_in,
	input wire [1:0] select,
	output wire tick_out
);

	reg [PS_W-1:0] div_count;
	reg [PS_W-1:0] terminal;

	// Terminal count for the chosen ratio
	always @* begin
		case (select)
			2'b00: terminal = `TMR_PS_TERM_1;
			2'b01: terminal = `TMR_PS_TERM_8;
			2'b10: terminal = `TMR_PS_TERM_64;
			2'b11: terminal = `TMR_PS_TERM_256;
			default: terminal = `TMR_PS_TERM_1;
		endcase
	end

	// One output tick per terminal+1 input ticks
	assign tick_out = tick_in && (div_count == terminal);

	// Divider count, cleared on stop or on a control or count write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_count <= {PS_W{1'b0}};
		end else if (clear) begin
			div_count <= {PS_W{1'b0}};
		end else if (tick_out) begin
			div_count <= {PS_W{1'b0}};
		end else if (tick_in) begin
			div_count <= div_count + 1'b1;
		end
	end

endmodule // tmr_prescaler

// ### core/tmr_timer.v
// Notes on behaviour
// (RQ1) Run bit set: 16-bit timer counts; cleared: timer halts, count held.
// (RQ2) Stop-in-idle set: timer halts during Idle; cleared: runs through Idle.
// (RQ3) Internal clock with gate bit: count only while gate high; ignored external.
// (RQ4) Prescale field 00/01/10/11 divides input by 1, 8, 64, 256.
// (RQ5) External clock: sync bit synchronizes input; ignored with internal clock.
// (RQ6) Source bit set: count rising edges of pin; clear: peripheral clock.
// (RQ7) Count writes ignored while running from synchronized external clock.
`timescale 1ns/1ns
`include "tmr_defines.vh"

module tmr_timer #(
	parameter CNT_W = `TMR_CNT_W,
	parameter PS_W = `TMR_PS_W
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`TMR_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire idle_mode,
	input wire external_clock_pin,
	output reg [CNT_W-1:0] timer_count,
	output reg timer_active
);

	// Control register and its fields
	reg [`TMR_CTL_W-1:0] timer_one_control;
	wire timer_run;
	wire stop_in_idle;
	wire gate_accumulate_enable;
	wire [1:0] input_prescale_select;
	wire external_clock_sync;
	wire clock_source_select;

	assign timer_run = timer_one_control[`TMR_BIT_RUN];
	assign stop_in_idle = timer_one_control[`TMR_BIT_SIDL];
	assign gate_accumulate_enable = timer_one_control[`TMR_BIT_GATE];
	assign input_prescale_select =
		timer_one_control[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO];
	assign external_clock_sync = timer_one_control[`TMR_BIT_SYNC];
	assign clock_source_select = timer_one_control[`TMR_BIT_TCS];

	// Pin sampling: two flip-flops, then history for edge detection
	reg pin_meta;
	reg pin_level;
	reg pin_prev;
	reg pin_sync_level;
	reg pin_sync_prev;

	// Bus decode
	wire bus_access;
	wire bus_commit;
	wire bus_write;
	wire hit_control;
	wire hit_count;
	wire hit_status;
	wire hit_any;
	reg [31:0] read_value;

	// Timer engine
	wire idle_halt;
	wire running;
	wire ext_edge_raw;
	wire ext_edge_synced;
	wire ext_edge;
	reg src_tick;
	wire ps_tick;
	wire ps_clear;
	wire count_lock;
	wire count_write;
	reg [CNT_W-1:0] next_count;

	// Two-stage synchroniser for the pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b0;
			pin_level <= 1'b0;
		end else begin
			pin_meta <= external_clock_pin;
			pin_level <= pin_meta;
		end
	end

	// Edge history: direct path and extra aligned stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev <= 1'b0;
			pin_sync_level <= 1'b0;
			pin_sync_prev <= 1'b0;
		end else begin
			pin_prev <= pin_level;
			pin_sync_level <= pin_level;
			pin_sync_prev <= pin_sync_level;
		end
	end

	// Rising-edge detection on the pin
	assign ext_edge_raw = pin_level && !pin_prev; // [RQ6]
	assign ext_edge_synced = pin_sync_level && !pin_sync_prev;

	// Sync bit picks the aligned path; unsync path has one cycle less delay
	assign ext_edge = external_clock_sync ? ext_edge_synced
		: ext_edge_raw; // [RQ5]

	// Run and idle qualification
	assign idle_halt = stop_in_idle && idle_mode; // [RQ2]
	assign running = timer_run && !idle_halt; // [RQ1]

	// Tick source: pin edges, gated peripheral clock, or peripheral clock
	always @* begin
		if (clock_source_select) begin
			src_tick = ext_edge; // [RQ6] [RQ3]
		end else if (gate_accumulate_enable) begin
			src_tick = pin_level; // [RQ3]
		end else begin
			src_tick = 1'b1; // [RQ6]
		end
	end

	// Prescaler restarts when stopped or when software writes control/count
	assign ps_clear = !running || (bus_write && (hit_control || hit_count));

	tmr_prescaler #(
		.PS_W(PS_W)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(ps_clear),
		.tick_in(running && src_tick),
		.select(input_prescale_select), // [RQ4]
		.tick_out(ps_tick)
	);

	// APB phases: access cycle, and the edge where pready is seen high
	assign bus_access = psel && penable;
	assign bus_commit = bus_access && pready;
	assign bus_write = bus_commit && pwrite;
	assign hit_control = (paddr == `TMR_OFF_CONTROL);
	assign hit_count = (paddr == `TMR_OFF_COUNT);
	assign hit_status = (paddr == `TMR_OFF_STATUS);
	assign hit_any = hit_control || hit_count || hit_status;

	// Count writes locked out while running from synchronized pin clock
	assign count_lock = timer_run && clock_source_select
		&& external_clock_sync; // [RQ7]
	assign count_write = bus_write && hit_count && !count_lock; // [RQ7]

	// Next count: accepted write wins over increment; halted holds
	always @* begin
		if (count_write) begin
			next_count = pwdata[CNT_W-1:0];
		end else if (ps_tick) begin
			next_count = timer_count + 1'b1; // [RQ1] [RQ4]
		end else begin
			next_count = timer_count; // [RQ1]
		end
	end

	// Counter register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count <= `TMR_CNT_RESET;
		end else begin
			timer_count <= next_count;
		end
	end

	// Running indication
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_active <= 1'b0;
		end else begin
			timer_active <= running;
		end
	end

	// Control register: only implemented bits take writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_one_control <= `TMR_CTL_RESET;
		end else if (bus_write && hit_control) begin
			timer_one_control <= pwdata[`TMR_CTL_W-1:0] & `TMR_CTL_WMASK;
		end
	end

	// Read multiplexer; unimplemented bits and unmapped addresses read 0
	always @* begin
		read_value = 32'h0000_0000;
		if (hit_control) begin
			read_value[`TMR_CTL_W-1:0] = timer_one_control;
		end else if (hit_count) begin
			read_value[CNT_W-1:0] = timer_count;
		end else if (hit_status) begin
			read_value[`TMR_ST_RUNNING] = running;
			read_value[`TMR_ST_IDLE_HALT] = idle_halt;
			read_value[`TMR_ST_PIN_LEVEL] = pin_level;
			read_value[`TMR_ST_WR_LOCK] = count_lock;
		end
	end

	// APB answer: one wait state, data and error registered with pready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (bus_access && !pready) begin
			pready <= 1'b1;
			pslverr <= !hit_any;
			prdata <= pwrite ? 32'h0000_0000 : read_value;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

endmodule // tmr_timer

// ### verification/test_timer1_control.sv
`timescale 1ns/1ns
`include "tmr_defines.vh"
`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		err_count++; \
		$display("Error t=%0t got %h exp %h", $time, a, b); \
	end \
end
module test_timer1_control;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, idle_mode = 1'b0, pslverr, pready, timer_active;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] half = 4'h0;
	logic [15:0] timer_count;
	wire external_clock_pin;
	int err_count = 0, cmp_count = 0;
	tmr_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .idle_mode,
		.external_clock_pin, .timer_count, .timer_active);
	tmr_pin_src i_src (.pclk, .half, .pin(external_clock_pin));
	always #2 pclk = ~pclk;
	task report_and_stop;
		$display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One bus transfer, waiting for ready under a bound
	task automatic apb(input bit w, input [11:0] a, input [31:0] d,
		output [31:0] r, output e);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			err_count++;
			report_and_stop;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input [11:0] a, input [31:0] x, input ex);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(r, x)
		`CHK(e, ex)
	endtask
	// Count advance over a steady window of n cycles
	task automatic m(input [15:0] c, input i, input [3:0] h,
		input int n, input [15:0] x);
		logic [15:0] c0;
		half <= h;
		idle_mode <= i;
		wr(`TMR_OFF_CONTROL, {16'h0, c});
		repeat (8) @(posedge pclk);
		c0 = timer_count;
		repeat (n) @(posedge pclk);
		`CHK(16'(timer_count - c0), x)
		`CHK(timer_active, c[15] && !(c[13] && i))
	endtask
	// Reset value, writable bits and an unmapped place
	task t_regs;
		rd(`TMR_OFF_CONTROL, 32'h0, 1'b0);
		wr(`TMR_OFF_CONTROL, 32'hffff);
		rd(`TMR_OFF_CONTROL, 32'ha076, 1'b0);
		rd(12'h00c, 32'h0, 1'b1);
	endtask
	// Count writes refused only with a synchronized external clock
	task t_lock;
		logic [15:0] c0;
		m(16'h8006, 1'b0, 4'h0, 16, 16'h0);
		c0 = timer_count;
		wr(`TMR_OFF_COUNT, 32'h1234);
		rd(`TMR_OFF_COUNT, {16'h0, c0}, 1'b0);
		rd(`TMR_OFF_STATUS, 32'h9, 1'b0);
		wr(`TMR_OFF_CONTROL, 32'h8002);
		wr(`TMR_OFF_COUNT, 32'h1234);
		rd(`TMR_OFF_COUNT, 32'h1234, 1'b0);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		m(16'h8000, 1'b0, 4'h0, 64, 16'd64);
		m(16'h0000, 1'b0, 4'h0, 32, 16'd0);
		m(16'h8010, 1'b0, 4'h0, 64, 16'd8);
		m(16'h8020, 1'b0, 4'h0, 128, 16'd2);
		m(16'h8030, 1'b0, 4'h0, 512, 16'd2);
		m(16'ha000, 1'b1, 4'h0, 32, 16'd0);
		m(16'h8000, 1'b1, 4'h0, 32, 16'd32);
		m(16'h8040, 1'b0, 4'h8, 64, 16'd32);
		m(16'h8040, 1'b0, 4'h0, 32, 16'd0);
		m(16'h8042, 1'b0, 4'h2, 64, 16'd16);
		m(16'h8006, 1'b0, 4'h2, 64, 16'd16);
		m(16'h8012, 1'b0, 4'h2, 64, 16'd2);
		t_lock;
		report_and_stop;
	end
endmodule // test_timer1_control
bind tmr_timer tmr_timer_sva #(.CNT_W(CNT_W)) i_sva (.pclk, .presetn,
	.psel, .penable, .pwrite, .prdata, .pready, .pslverr, .timer_count,
	.timer_active);

// ### verification/tmr_pin_src.sv
`timescale 1ns/1ns
module tmr_pin_src (
	input wire pclk,
	input wire [3:0] half,
	output reg pin
);
	reg [3:0] cnt;
	initial pin = 1'b0;
	initial cnt = 4'h0;
	// Square wave, half periods of half cycles; rests low when half is 0
	always @(posedge pclk) begin
		if (half == 4'h0) begin
			pin <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt >= half - 4'h1) begin
			pin <= !pin;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // tmr_pin_src

// ### verification/tmr_timer_sva.sv
`timescale 1ns/1ns
module tmr_timer_sva #(
	parameter CNT_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [CNT_W-1:0] timer_count,
	input wire timer_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus write committing at this edge
	wire wr_commit = psel && penable && pready && pwrite;
	count_step_a:
	assert property ($changed(timer_count) && !$past(wr_commit)
		|-> timer_count == $past(timer_count) + 1'b1)
		else $error("count moved by other than one");
	count_hold_a:
	assert property (!timer_active && !$past(timer_active)
		&& !$past(wr_commit) |-> $stable(timer_count))
		else $error("count moved while halted");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	access_len_a: assert property ($rose(penable) && psel
		|-> !pready ##1 pready)
		else $error("access phase not two cycles");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready cycle");
	rdata_upper_a: assert property (pready && !pwrite
		|-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
endmodule // tmr_timer_sva
